// ### design/iwsc_pkg.sv
package iwsc_pkg;

  // register offsets on the plain register port
  localparam logic [13:0] STATUS_OFS = 14'h0003;
  localparam logic [13:0] IRQ_CTRL_OFS = 14'h000B;
  localparam logic [13:0] PERIPH_FLAG_OFS = 14'h000C;
  localparam logic [13:0] PRESCALE_CFG_OFS = 14'h0081;
  localparam logic [13:0] PERIPH_EN_OFS = 14'h008C;
  localparam logic [13:0] DEV_CONFIG_OFS = 14'h2007;

  // irq_control_reg fields
  localparam int PORT_CHANGE_FLAG_BIT = 0;
  localparam int EXT_PIN_FLAG_BIT = 1;
  localparam int TIMER_WRAP_FLAG_BIT = 2;
  localparam int PORT_CHANGE_EN_BIT = 3;
  localparam int EXT_PIN_EN_BIT = 4;
  localparam int TIMER_WRAP_EN_BIT = 5;
  localparam int PERIPH_GROUP_EN_BIT = 6;
  localparam int GLOBAL_IRQ_EN_BIT = 7;

  // prescale_edge_config fields
  localparam int PRESCALE_RATIO_LSB = 0;
  localparam int PRESCALER_ASSIGN_BIT = 3;
  localparam int EXT_EDGE_SELECT_BIT = 6;

  // device_config_word and status fields
  localparam int WATCHDOG_FUSE_EN_BIT = 2;
  localparam int POWER_DOWN_N_BIT = 3;
  localparam int WATCHDOG_EXPIRED_N_BIT = 4;

  // values after reset
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic [7:0] PRESCALE_CFG_RST = 8'hFF;
  localparam logic [7:0] DEV_CONFIG_RST = 8'hFF;
  localparam logic [7:0] PERIPH_RST = 8'h00;

  // interrupt vector
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;

  // watchdog timing: nominal period and its own oscillator rate
  localparam int WDT_TIMEOUT_US = 18000;
  localparam int WDT_OSC_KHZ_DEF = 100;
  localparam int WDT_TICKS_DEF = WDT_TIMEOUT_US * WDT_OSC_KHZ_DEF / 1000;

  typedef struct packed {
    logic kick;
    logic sleep;
    logic return_from_isr_op;
    logic [12:0] ret_pc;
  } iwsc_core_req_t;

  typedef struct packed {
    logic take;
    logic pop;
    logic [12:0] push_addr;
    logic [12:0] vector;
  } iwsc_core_rsp_t;

endpackage : iwsc_pkg

// ### design/iwsc_top.sv
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ns
module iwsc_top #(
  parameter int NUM_PERIPH = 1,
  parameter int WDT_OSC_KHZ = iwsc_pkg::WDT_OSC_KHZ_DEF,
  parameter int WDT_TICKS = iwsc_pkg::WDT_TIMEOUT_US * WDT_OSC_KHZ / 1000
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [13:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // processor core
  input wire iwsc_pkg::iwsc_core_req_t core_req_i,
  output iwsc_pkg::iwsc_core_rsp_t core_rsp_o,
  // event sources
  input wire logic ext_irq_pin_i,
  input wire logic [3:0] second_port_hi_i,
  input wire logic free_timer_wrap_i,
  input wire logic [NUM_PERIPH-1:0] periph_event_i,
  input wire logic wdt_osc_i,
  // power and reset control
  output logic osc_drive_en_o,
  output logic port_hold_o,
  output logic wake_o,
  output logic wdt_reset_o
);

  logic [7:0] irq_ctrl_r;
  logic [7:0] irq_ctrl_nxt;
  logic [7:0] prescale_cfg_r;
  logic [7:0] dev_config_r;
  logic [NUM_PERIPH-1:0] periph_flag_r;
  logic [NUM_PERIPH-1:0] periph_flag_nxt;
  logic [NUM_PERIPH-1:0] periph_en_r;
  logic watchdog_expired_n_r;
  logic power_down_n_r;
  logic sleeping_r;

  // two-flop synchronisers plus one history stage for edge detection
  logic [2:0] ext_pin_sync_r;
  logic [3:0] port_s1_r;
  logic [3:0] port_s2_r;
  logic [3:0] port_last_r;
  logic [2:0] wdt_osc_sync_r;

  logic wr_irq_ctrl;
  logic wr_periph_flag;
  logic ext_edge_ev;
  logic port_change_ev;
  logic osc_tick;
  logic periph_pending;
  logic irq_pending;
  logic take_irq;
  logic sleep_go;
  logic wdt_enable;
  logic wdt_timeout;

  assign wr_irq_ctrl = reg_wr_i && (reg_addr_i == iwsc_pkg::IRQ_CTRL_OFS);
  assign wr_periph_flag = reg_wr_i && (reg_addr_i == iwsc_pkg::PERIPH_FLAG_OFS);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ext_pin_sync_r <= 3'h0;
      port_s1_r <= 4'h0;
      port_s2_r <= 4'h0;
      port_last_r <= 4'h0;
      wdt_osc_sync_r <= 3'h0;
    end else begin
      ext_pin_sync_r <= {ext_pin_sync_r[1:0], ext_irq_pin_i};
      port_s1_r <= second_port_hi_i;
      port_s2_r <= port_s1_r;
      port_last_r <= port_s2_r;
      wdt_osc_sync_r <= {wdt_osc_sync_r[1:0], wdt_osc_i};
    end
  end

  // edge polarity chosen by the edge-select option bit
  assign ext_edge_ev = prescale_cfg_r[iwsc_pkg::EXT_EDGE_SELECT_BIT] ?
                       (ext_pin_sync_r[1] && !ext_pin_sync_r[2]) :
                       (!ext_pin_sync_r[1] && ext_pin_sync_r[2]);
  assign port_change_ev = (port_s2_r != port_last_r);
  assign osc_tick = wdt_osc_sync_r[1] && !wdt_osc_sync_r[2];

  assign periph_pending = irq_ctrl_r[iwsc_pkg::PERIPH_GROUP_EN_BIT] &&
                          |(periph_flag_r & periph_en_r);
  // pending ignores the global enable: it is also the wake condition
  assign irq_pending =
    (irq_ctrl_r[iwsc_pkg::PORT_CHANGE_FLAG_BIT] && irq_ctrl_r[iwsc_pkg::PORT_CHANGE_EN_BIT]) ||
    (irq_ctrl_r[iwsc_pkg::EXT_PIN_FLAG_BIT] && irq_ctrl_r[iwsc_pkg::EXT_PIN_EN_BIT]) ||
    (irq_ctrl_r[iwsc_pkg::TIMER_WRAP_FLAG_BIT] && irq_ctrl_r[iwsc_pkg::TIMER_WRAP_EN_BIT]) ||
    periph_pending;
  assign take_irq = irq_ctrl_r[iwsc_pkg::GLOBAL_IRQ_EN_BIT] && irq_pending && !sleeping_r;
  assign sleep_go = core_req_i.sleep && !irq_pending && !sleeping_r;

  // flag set from hardware wins over a software write in the same cycle
  always_comb begin
    irq_ctrl_nxt = wr_irq_ctrl ? reg_wdata_i : irq_ctrl_r;
    irq_ctrl_nxt[iwsc_pkg::EXT_PIN_FLAG_BIT] =
      irq_ctrl_nxt[iwsc_pkg::EXT_PIN_FLAG_BIT] | ext_edge_ev;
    irq_ctrl_nxt[iwsc_pkg::TIMER_WRAP_FLAG_BIT] =
      irq_ctrl_nxt[iwsc_pkg::TIMER_WRAP_FLAG_BIT] | free_timer_wrap_i;
    irq_ctrl_nxt[iwsc_pkg::PORT_CHANGE_FLAG_BIT] =
      irq_ctrl_nxt[iwsc_pkg::PORT_CHANGE_FLAG_BIT] | port_change_ev;
    if (take_irq) begin
      irq_ctrl_nxt[iwsc_pkg::GLOBAL_IRQ_EN_BIT] = 1'b0;
    end else if (core_req_i.return_from_isr_op) begin
      irq_ctrl_nxt[iwsc_pkg::GLOBAL_IRQ_EN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      irq_ctrl_r <= iwsc_pkg::IRQ_CTRL_RST;
    end else begin
      irq_ctrl_r <= irq_ctrl_nxt;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
      assign periph_flag_nxt[gi] = (wr_periph_flag ? reg_wdata_i[gi] : periph_flag_r[gi]) |
                                   periph_event_i[gi];
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      periph_flag_r <= '0;
      periph_en_r <= '0;
    end else begin
      periph_flag_r <= periph_flag_nxt;
      if (reg_wr_i && (reg_addr_i == iwsc_pkg::PERIPH_EN_OFS)) begin
        periph_en_r <= reg_wdata_i[NUM_PERIPH-1:0];
      end
    end
  end

  // the fuse bit can only be cleared, so software cannot revive the watchdog
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      prescale_cfg_r <= iwsc_pkg::PRESCALE_CFG_RST;
      dev_config_r <= iwsc_pkg::DEV_CONFIG_RST;
    end else begin
      if (reg_wr_i && (reg_addr_i == iwsc_pkg::PRESCALE_CFG_OFS)) begin
        prescale_cfg_r <= reg_wdata_i;
      end
      if (reg_wr_i && (reg_addr_i == iwsc_pkg::DEV_CONFIG_OFS)) begin
        dev_config_r <= reg_wdata_i &
          ~(8'h01 << iwsc_pkg::WATCHDOG_FUSE_EN_BIT) |
          (reg_wdata_i & dev_config_r & (8'h01 << iwsc_pkg::WATCHDOG_FUSE_EN_BIT));
      end
    end
  end

  assign wdt_enable = dev_config_r[iwsc_pkg::WATCHDOG_FUSE_EN_BIT];

  iwsc_wdt #(
    .WDT_TICKS(WDT_TICKS)
  ) u_wdt (
    .mclk_i(mclk_i),
    .resetn_i(resetn_i),
    .osc_tick_i(osc_tick),
    .enable_i(wdt_enable),
    .clear_i(core_req_i.kick || sleep_go),
    .use_prescale_i(prescale_cfg_r[iwsc_pkg::PRESCALER_ASSIGN_BIT]),
    .ratio_i(prescale_cfg_r[iwsc_pkg::PRESCALE_RATIO_LSB +: 3]),
    .timeout_o(wdt_timeout)
  );

  // power-down state and status bits; the main oscillator is modelled by its enable
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      sleeping_r <= 1'b0;
      watchdog_expired_n_r <= 1'b1;
      power_down_n_r <= 1'b1;
      osc_drive_en_o <= 1'b1;
      port_hold_o <= 1'b0;
      wake_o <= 1'b0;
      wdt_reset_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      wdt_reset_o <= 1'b0;
      if (sleep_go) begin
        sleeping_r <= 1'b1;
        power_down_n_r <= 1'b0;
        watchdog_expired_n_r <= 1'b1;
        osc_drive_en_o <= 1'b0;
        port_hold_o <= 1'b1;
      end else if (sleeping_r && (irq_pending || wdt_timeout)) begin
        sleeping_r <= 1'b0;
        osc_drive_en_o <= 1'b1;
        port_hold_o <= 1'b0;
        wake_o <= 1'b1;
        if (wdt_timeout) begin
          watchdog_expired_n_r <= 1'b0;
        end
      end else if (wdt_timeout) begin
        watchdog_expired_n_r <= 1'b0;
        wdt_reset_o <= 1'b1;
      end
    end
  end

  // only the return address goes out; accumulator and status stay with software
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      core_rsp_o <= '0;
    end else begin
      core_rsp_o.take <= take_irq;
      core_rsp_o.pop <= core_req_i.return_from_isr_op;
      core_rsp_o.vector <= iwsc_pkg::IRQ_VECTOR;
      if (take_irq) begin
        core_rsp_o.push_addr <= core_req_i.ret_pc;
      end
    end
  end

  // read data one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        iwsc_pkg::IRQ_CTRL_OFS: reg_rdata_o <= irq_ctrl_r;
        iwsc_pkg::PRESCALE_CFG_OFS: reg_rdata_o <= prescale_cfg_r;
        iwsc_pkg::DEV_CONFIG_OFS: reg_rdata_o <= dev_config_r;
        iwsc_pkg::PERIPH_FLAG_OFS: reg_rdata_o <= 8'(periph_flag_r);
        iwsc_pkg::PERIPH_EN_OFS: reg_rdata_o <= 8'(periph_en_r);
        iwsc_pkg::STATUS_OFS: reg_rdata_o <=
          (8'(watchdog_expired_n_r) << iwsc_pkg::WATCHDOG_EXPIRED_N_BIT) |
          (8'(power_down_n_r) << iwsc_pkg::POWER_DOWN_N_BIT);
        default: reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  AST_FLAG_IGNORES_ENABLE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    free_timer_wrap_i |=> irq_ctrl_r[iwsc_pkg::TIMER_WRAP_FLAG_BIT])
    else $error("timer wrap did not set its flag");

  AST_NO_TAKE_WITHOUT_GIE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    core_rsp_o.take |-> $past(irq_ctrl_r[iwsc_pkg::GLOBAL_IRQ_EN_BIT]))
    else $error("interrupt taken with global enable clear");

  AST_TAKE_IMMEDIATE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (irq_ctrl_r[iwsc_pkg::GLOBAL_IRQ_EN_BIT] && irq_pending && !sleeping_r) |=>
    (core_rsp_o.take && !irq_ctrl_r[iwsc_pkg::GLOBAL_IRQ_EN_BIT]))
    else $error("interrupt entry not started next cycle");

  AST_ENTRY_VECTOR: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    core_rsp_o.take |-> (core_rsp_o.vector == 13'h0004) &&
    (core_rsp_o.push_addr == $past(core_req_i.ret_pc)))
    else $error("entry vector or pushed address wrong");

  AST_RETURN_FROM_ISR_OP_SETS_GIE: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (core_req_i.return_from_isr_op && !take_irq) |=>
    (core_rsp_o.pop && irq_ctrl_r[iwsc_pkg::GLOBAL_IRQ_EN_BIT]))
    else $error("return did not pop and re-enable");

  AST_EXT_LATENCY: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (ext_edge_ev && irq_ctrl_r[iwsc_pkg::EXT_PIN_EN_BIT] &&
     irq_ctrl_r[iwsc_pkg::GLOBAL_IRQ_EN_BIT] && !sleeping_r && !take_irq && !wr_irq_ctrl)
    |=> ##1 core_rsp_o.take)
    else $error("pin interrupt latency exceeded");

  AST_SLEEP_STATUS: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    sleep_go |=> (!power_down_n_r && watchdog_expired_n_r && !osc_drive_en_o && port_hold_o))
    else $error("power-down status not applied");

  AST_SLEEP_AS_NOP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (core_req_i.sleep && irq_pending && !sleeping_r) |=>
    ($stable(power_down_n_r) && !sleeping_r && osc_drive_en_o))
    else $error("power-down not skipped with pending interrupt");

  AST_TIMEOUT_STATUS: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (wdt_timeout && !sleep_go) |=> (!watchdog_expired_n_r && (wdt_reset_o ^ wake_o)))
    else $error("timeout did not clear status or act");

  AST_FUSE_OFF: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !wdt_enable |=> !wdt_timeout)
    else $error("watchdog fired with fuse cleared");

  AST_PIN_EDGE_FLAG: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ext_edge_ev |=> irq_ctrl_r[iwsc_pkg::EXT_PIN_FLAG_BIT])
    else $error("pin edge did not set its flag");

  AST_PORT_CHANGE_FLAG: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    port_change_ev |=> irq_ctrl_r[iwsc_pkg::PORT_CHANGE_FLAG_BIT])
    else $error("port change did not set its flag");

  AST_SET_BEATS_CLEAR: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (free_timer_wrap_i && wr_irq_ctrl) |=> irq_ctrl_r[iwsc_pkg::TIMER_WRAP_FLAG_BIT])
    else $error("software write lost a timer wrap request");

  AST_WAKE_ON_PENDING: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (sleeping_r && irq_pending) |=> (wake_o && !sleeping_r && osc_drive_en_o))
    else $error("enabled request did not wake the device");

  AST_HOLD_WHILE_ASLEEP: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    sleeping_r |-> (port_hold_o && !osc_drive_en_o))
    else $error("ports not held or oscillator running in power-down");

endmodule : iwsc_top

// ### design/iwsc_wdt.sv
`timescale 1ns/1ns
module iwsc_wdt #(
  parameter int WDT_TICKS = iwsc_pkg::WDT_TICKS_DEF
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // control
  input wire logic osc_tick_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic use_prescale_i,
  input wire logic [2:0] ratio_i,
  // status
  output logic timeout_o
);

  logic [6:0] pre_cnt_r;
  logic [15:0] main_cnt_r;
  logic [6:0] pre_mask;
  logic stage_tick;

  assign pre_mask = 7'((8'h01 << ratio_i) - 8'h01);
  assign stage_tick = osc_tick_i && (!use_prescale_i || (pre_cnt_r == pre_mask));

  // prescaler is shared with the timer, so it is only cleared while assigned here
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pre_cnt_r <= 7'h00;
    end else if (use_prescale_i && (clear_i || !enable_i)) begin
      pre_cnt_r <= 7'h00;
    end else if (use_prescale_i && osc_tick_i) begin
      pre_cnt_r <= (pre_cnt_r == pre_mask) ? 7'h00 : 7'(pre_cnt_r + 7'h01);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      main_cnt_r <= 16'h0000;
      timeout_o <= 1'b0;
    end else begin
      timeout_o <= 1'b0;
      if (clear_i || !enable_i) begin
        main_cnt_r <= 16'h0000;
      end else if (stage_tick) begin
        if (main_cnt_r == 16'(WDT_TICKS - 1)) begin
          main_cnt_r <= 16'h0000;
          timeout_o <= 1'b1;
        end else begin
          main_cnt_r <= 16'(main_cnt_r + 16'h0001);
        end
      end
    end
  end

endmodule : iwsc_wdt

// ### dv/irq_watchdog_sleep_ctrl_test.sv
`timescale 1ns/1ns
module irq_watchdog_sleep_ctrl_test;
  typedef struct packed {
    logic [13:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } iwsc_row_t;
  logic mclk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [13:0] reg_addr_i = 14'h0000;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, rd;
  logic pin = 1'b0, twrap = 1'b0, pev = 1'b0, wdt_osc = 1'b0, wdt_on = 1'b0;
  logic [3:0] port_hi = 4'h0;
  logic kick = 1'b0, slp = 1'b0, rfi = 1'b0, osc_en, hold, wake, wrst;
  logic [12:0] pc;
  iwsc_pkg::iwsc_core_req_t req;
  iwsc_pkg::iwsc_core_rsp_t rsp;
  int n_fail = 0, samples_checked = 0, n_take = 0, n_pop = 0, n_wake = 0, n_rst = 0;
  int lat, s;
  iwsc_row_t rows [11] = '{
    '{iwsc_pkg::IRQ_CTRL_OFS, 1'b0, 8'h00, 8'h00},
    '{iwsc_pkg::PRESCALE_CFG_OFS, 1'b0, 8'h00, 8'hFF},
    '{iwsc_pkg::DEV_CONFIG_OFS, 1'b0, 8'h00, 8'hFF},
    '{iwsc_pkg::PERIPH_FLAG_OFS, 1'b0, 8'h00, 8'h00},
    '{iwsc_pkg::PERIPH_EN_OFS, 1'b0, 8'h00, 8'h00},
    '{iwsc_pkg::PERIPH_EN_OFS, 1'b1, 8'h01, 8'h01},
    '{14'h0050, 1'b1, 8'h5A, 8'h00},
    '{iwsc_pkg::IRQ_CTRL_OFS, 1'b1, 8'h78, 8'h78},
    '{iwsc_pkg::IRQ_CTRL_OFS, 1'b1, 8'h00, 8'h00},
    '{iwsc_pkg::PRESCALE_CFG_OFS, 1'b1, 8'hF7, 8'hF7},
    '{iwsc_pkg::STATUS_OFS, 1'b1, 8'h00, 8'h18}};

  always #10 mclk_i = ~mclk_i;
  // the watchdog oscillator only runs when a case needs it, 10 clocks a period
  always #100 wdt_osc = wdt_on ? ~wdt_osc : 1'b0;
  always @(posedge mclk_i) begin
    n_take <= n_take + int'(rsp.take);
    n_pop <= n_pop + int'(rsp.pop);
    n_wake <= n_wake + int'(wake);
    n_rst <= n_rst + int'(wrst);
  end

  iwsc_top #(.WDT_TICKS(4)) i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .core_req_i(req), .core_rsp_o(rsp),
    .ext_irq_pin_i(pin), .second_port_hi_i(port_hi), .free_timer_wrap_i(twrap),
    .periph_event_i(pev), .wdt_osc_i(wdt_osc), .osc_drive_en_o(osc_en),
    .port_hold_o(hold), .wake_o(wake), .wdt_reset_o(wrst));
  iwsc_core_model i_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .kick_cmd_i(kick),
    .sleep_cmd_i(slp), .return_from_isr_op_cmd_i(rfi), .core_rsp_i(rsp), .osc_drive_en_i(osc_en),
    .core_req_o(req), .pc_o(pc));

  task automatic finish_test;
    if (n_fail == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic cmp(input string nm, input logic [12:0] e, input logic [12:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : cmp

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rdc(input string nm, input logic [13:0] a, input logic [7:0] m,
                     input logic [7:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 cmp(nm, e, reg_rdata_o & m);
  endtask : rdc

  function automatic int ev(input int k);
    return k == 0 ? n_take : k == 1 ? n_pop : k == 2 ? n_wake : n_rst;
  endfunction : ev

  task automatic wait_ev(input int k, input int lim);
    int s0;
    s0 = ev(k);
    for (int i = 0; i < lim && ev(k) == s0; i++) @(posedge mclk_i);
    #1;
    if (ev(k) == s0) begin
      cmp("event_wait", 13'h0001, 13'h0000);
      finish_test();
    end
  endtask : wait_ev

  localparam int P_WRAP = 0, P_SLP = 1, P_RFI = 2, P_PIN = 3, P_PEV = 4, P_KICK = 5;

  task automatic drive(input int k, input logic v);
    case (k)
      P_WRAP: twrap <= v;
      P_SLP: slp <= v;
      P_RFI: rfi <= v;
      P_PIN: pin <= v;
      P_PEV: pev <= v;
      default: kick <= v;
    endcase
  endtask : drive

  task automatic pulse(input int k);
    @(posedge mclk_i);
    drive(k, 1'b1);
    @(posedge mclk_i);
    drive(k, 1'b0);
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : idle

  initial begin
    idle(3);
    resetn_i <= 1'b1;
    rdc("status_rst", iwsc_pkg::STATUS_OFS, 8'h18, 8'h18);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rdc("reg_row", rows[i].a, 8'hFF, rows[i].e);
    end
    pulse(P_WRAP);
    rdc("flag_no_en", iwsc_pkg::IRQ_CTRL_OFS, 8'hFF, 8'h04);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= iwsc_pkg::IRQ_CTRL_OFS;
    reg_wdata_i <= 8'h00;
    twrap <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    twrap <= 1'b0;
    rdc("set_beats_clear", iwsc_pkg::IRQ_CTRL_OFS, 8'hFF, 8'h04);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'h24);
    pulse(P_SLP);
    idle(2);
    cmp("sleep_noop_osc", 13'h0001, osc_en);
    rdc("sleep_noop_st", iwsc_pkg::STATUS_OFS, 8'h18, 8'h18);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'hA4);
    wait_ev(0, 10);
    cmp("vector", iwsc_pkg::IRQ_VECTOR, rsp.vector);
    rdc("gie_cleared", iwsc_pkg::IRQ_CTRL_OFS, 8'hFF, 8'h24);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'h20);
    pulse(P_RFI);
    #1 cmp("pop", 13'h0001, rsp.pop);
    rdc("gie_set", iwsc_pkg::IRQ_CTRL_OFS, 8'hFF, 8'hA0);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'hB0);
    @(posedge mclk_i);
    pin <= 1'b1;
    // latency counted in whole cycles up to the cycle in which take stands
    for (lat = 0; lat < 10 && !rsp.take; lat++) begin
      @(posedge mclk_i);
      #1;
    end
    cmp("latency_ok", 13'h0001, 13'(lat == 3 || lat == 4));
    rdc("pin_flag", iwsc_pkg::IRQ_CTRL_OFS, 8'hFF, 8'h32);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'h30);
    wr(iwsc_pkg::PRESCALE_CFG_OFS, 8'hB7);
    pulse(P_PIN);
    idle(4);
    rdc("fall_only", iwsc_pkg::IRQ_CTRL_OFS, 8'hFF, 8'h32);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'h88);
    @(posedge mclk_i);
    port_hi <= 4'hA;
    for (lat = 0; lat < 10 && !rsp.take; lat++) begin
      @(posedge mclk_i);
      #1;
    end
    cmp("port_latency", 13'h0001, 13'(lat == 3 || lat == 4));
    rdc("port_flag", iwsc_pkg::IRQ_CTRL_OFS, 8'hFF, 8'h09);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'h80);
    wr(iwsc_pkg::PRESCALE_CFG_OFS, 8'hF7);
    s = n_take;
    pulse(P_PEV);
    idle(4);
    cmp("group_gate", s, n_take);
    rdc("periph_flag", iwsc_pkg::PERIPH_FLAG_OFS, 8'hFF, 8'h01);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'hC0);
    wait_ev(0, 10);
    wr(iwsc_pkg::PERIPH_FLAG_OFS, 8'h00);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'h10);
    pulse(P_SLP);
    idle(2);
    cmp("sleep_osc", 13'h0000, osc_en);
    cmp("sleep_hold", 13'h0001, hold);
    rdc("sleep_st", iwsc_pkg::STATUS_OFS, 8'h18, 8'h10);
    s = n_take;
    pulse(P_PIN);
    wait_ev(2, 10);
    idle(3);
    cmp("no_vector", s, n_take);
    cmp("awake_osc", 13'h0001, osc_en);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'h00);
    pulse(P_KICK);
    pulse(P_SLP);
    wdt_on <= 1'b1;
    wait_ev(2, 200);
    rdc("wdt_wake_st", iwsc_pkg::STATUS_OFS, 8'h18, 8'h00);
    cmp("no_reset_asleep", 13'h0000, 13'(n_rst));
    repeat (6) begin
      pulse(P_KICK);
      idle(18);
    end
    cmp("kicked", 13'h0000, 13'(n_rst));
    wait_ev(3, 200);
    // a timeout while awake clears only bit 4 and pulses the reset, so bit 3 stays from power-down
    rdc("wdt_rst_st", iwsc_pkg::STATUS_OFS, 8'h18, 8'h00);
    pulse(P_KICK);
    wr(iwsc_pkg::PRESCALE_CFG_OFS, 8'hF9);
    pulse(P_KICK);
    s = n_rst;
    idle(60);
    cmp("prescaled", s, n_rst);
    wait_ev(3, 40);
    wr(iwsc_pkg::DEV_CONFIG_OFS, 8'hFB);
    wr(iwsc_pkg::DEV_CONFIG_OFS, 8'hFF);
    rdc("fuse_sticky", iwsc_pkg::DEV_CONFIG_OFS, 8'hFF, 8'hFB);
    s = n_rst;
    idle(200);
    cmp("fuse_off", s, n_rst);
    wr(iwsc_pkg::IRQ_CTRL_OFS, 8'h80);
    resetn_i <= 1'b0;
    idle(3);
    resetn_i <= 1'b1;
    rdc("gie_reset", iwsc_pkg::IRQ_CTRL_OFS, 8'hFF, 8'h00);
    finish_test();
  end
endmodule : irq_watchdog_sleep_ctrl_test

// ### dv/iwsc_core_model.sv
`timescale 1ns/1ns
module iwsc_core_model (
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // commands from the bench, one cycle each
  input wire logic kick_cmd_i,
  input wire logic sleep_cmd_i,
  input wire logic return_from_isr_op_cmd_i,
  // block side
  input wire iwsc_pkg::iwsc_core_rsp_t core_rsp_i,
  input wire logic osc_drive_en_i,
  output iwsc_pkg::iwsc_core_req_t core_req_o,
  output logic [12:0] pc_o
);
  logic [12:0] stack_r;

  assign core_req_o.kick = kick_cmd_i;
  assign core_req_o.sleep = sleep_cmd_i;
  assign core_req_o.return_from_isr_op = return_from_isr_op_cmd_i;
  assign core_req_o.ret_pc = pc_o;

  // only the return pc is kept; accumulator and status are software's job
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      pc_o <= 13'h0000;
      stack_r <= 13'h0000;
    end else if (core_rsp_i.take) begin
      stack_r <= core_rsp_i.push_addr;
      pc_o <= core_rsp_i.vector;
    end else if (core_rsp_i.pop) begin
      pc_o <= stack_r;
    end else if (osc_drive_en_i) begin
      pc_o <= pc_o + 13'h0001;
    end
  end
endmodule : iwsc_core_model
